/* File: hw/adcseq_top.sv */
`timescale 1ns/100ps
`include "adcseq_cfg.svh"

module adcseq_top
  import adcseq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic sleep_i,
  input wire logic special_trigger_i,
  input wire logic comparator_i,
  output adcseq_ana_t analog_o,
  output logic timer_clear_o,
  output logic done_flag_o,
  output logic wake_o,
  output logic [1:0] ref_select_o
);

  //////////////////////////////////////////////////////////////////////////
  // register state
  adcseq_aphase_t aph_q;
  logic [3:0] chs_q;
  logic go_q, go_d;
  logic on_q;
  logic [2:0] cs_q;
  logic [1:0] ref_q;
  logic [7:0] result_q;
  logic flag_q, irq_en_q;
  logic pd_q;
  logic [31:0] rdata_q;
  logic timer_clear_q;
  adcseq_state_t state_q;
  logic [6:0] div_q;
  logic [6:0] rc_q;
  logic [3:0] tad_q;
  logic [2:0] dly_q;
  logic [7:0] trial_q;
  logic [3:0] nres_q;
  logic last_q;
  logic hold_q;
  //////////////////////////////////////////////////////////////////////////
  // bus slave, always zero wait state, always okay
  logic wr, ctl_wr, cfg_wr, res_wr, irq_wr;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_q;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      aph_q <= '0;
    end else if (hready_i) begin
      aph_q.valid <= hsel_i & htrans_i[1];
      aph_q.write <= hwrite_i;
      aph_q.addr <= haddr_i[7:0];
    end
  end
  assign wr = aph_q.valid & aph_q.write;
  assign ctl_wr = wr & (aph_q.addr == `ADCSEQ_OFF_CTL);
  assign cfg_wr = wr & (aph_q.addr == `ADCSEQ_OFF_CFG);
  assign res_wr = wr & (aph_q.addr == `ADCSEQ_OFF_RES);
  assign irq_wr = wr & (aph_q.addr == `ADCSEQ_OFF_IRQ);

  // read data captured in the address phase; unmapped reads zero
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (hready_i & hsel_i & htrans_i[1] & ~hwrite_i) begin
      unique case (haddr_i[7:0])
        `ADCSEQ_OFF_CTL: rdata_q <= {26'h0, chs_q, go_q, on_q};
        `ADCSEQ_OFF_CFG: rdata_q <= {25'h0, cs_q, 2'b00, ref_q};
        `ADCSEQ_OFF_RES: rdata_q <= {24'h0, result_q};
        `ADCSEQ_OFF_IRQ: rdata_q <= {30'h0, irq_en_q, flag_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      chs_q <= 4'h0;
      on_q <= 1'b0;
    end else if (ctl_wr) begin
      chs_q <= hwdata_i[`ADCSEQ_CTL_CHS_HI:`ADCSEQ_CTL_CHS_LO];
      on_q <= hwdata_i[`ADCSEQ_CTL_ON];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cs_q <= 3'h0;
      ref_q <= 2'h0;
    end else if (cfg_wr) begin
      cs_q <= hwdata_i[`ADCSEQ_CFG_CS_HI:`ADCSEQ_CFG_CS_LO];
      ref_q <= hwdata_i[`ADCSEQ_CFG_REF_HI:`ADCSEQ_CFG_REF_LO];
    end
  end

  assign ref_select_o = ref_q;

  //////////////////////////////////////////////////////////////////////////
  // clock select decode and bit period tick
  logic use_rc;
  logic [6:0] div_len;
  logic rc_tick, sys_tick, tad_tick;
  assign use_rc = (cs_q[1:0] == 2'b11);
  always_comb begin
    unique case (cs_q)
      3'b000: div_len = 7'd2;
      3'b001: div_len = 7'd8;
      3'b010: div_len = 7'd32;
      3'b100: div_len = 7'd4;
      3'b101: div_len = 7'd16;
      3'b110: div_len = 7'd64;
      default: div_len = 7'd1;
    endcase
  end

  // free running stand-in for the dedicated RC oscillator
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rc_q <= 7'h00;
    end else if (rc_q == 7'(`ADCSEQ_RC_DIV - 1)) begin
      rc_q <= 7'h00;
    end else begin
      rc_q <= rc_q + 7'h01;
    end
  end

  assign rc_tick = (rc_q == 7'(`ADCSEQ_RC_DIV - 1));
  assign sys_tick = (div_q == div_len - 7'h01);
  assign tad_tick = use_rc ? rc_tick : sys_tick;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      div_q <= 7'h00;
    end else if (state_q != ADCSEQ_CONV || sys_tick) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // start, finish and abort conditions
  logic powered, busy, start, finish, last_bit;
  logic sw_abort, sleep_abort, sleep_pd_finish;
  logic [2:0] bit_idx;
  logic [7:0] resolved;
  assign powered = on_q & ~pd_q;
  assign busy = (state_q != ADCSEQ_IDLE);
  assign start = (state_q == ADCSEQ_IDLE) & go_q & powered;
  assign finish = (state_q == ADCSEQ_CONV) & tad_tick &
                  (tad_q == 4'(`ADCSEQ_TAD_PER_CONV - 1));
  assign sw_abort = busy & ctl_wr & ~hwdata_i[`ADCSEQ_CTL_GO] &
                    ~special_trigger_i;
  assign sleep_abort = busy & sleep_i & ~use_rc;
  assign sleep_pd_finish = finish & sleep_i & ~irq_en_q;

  // bit periods 1..8 resolve bits 7..0
  assign bit_idx = 3'(4'd8 - tad_q);
  assign last_bit = (state_q == ADCSEQ_CONV) & tad_tick &
                    (tad_q >= 4'd1) & (tad_q <= 4'd8);

  always_comb begin
    resolved = trial_q;
    resolved[bit_idx] = comparator_i;
  end

  // go: any hardware or software set beats a clear in the same cycle
  always_comb begin
    go_d = go_q;
    if (finish | sleep_abort | (ctl_wr & ~hwdata_i[`ADCSEQ_CTL_GO]) |
        ((state_q == ADCSEQ_IDLE) & go_q & ~powered)) begin
      go_d = 1'b0;
    end
    if (ctl_wr & hwdata_i[`ADCSEQ_CTL_GO]) begin
      go_d = 1'b1;
    end
    if (special_trigger_i) begin
      go_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      go_q <= 1'b0;
    end else begin
      go_q <= go_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      timer_clear_q <= 1'b0;
    end else begin
      timer_clear_q <= special_trigger_i;
    end
  end

  assign timer_clear_o = timer_clear_q;

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q <= ADCSEQ_IDLE;
      dly_q <= 3'h0;
      tad_q <= 4'h0;
    end else if (sleep_abort | sw_abort | finish) begin
      state_q <= ADCSEQ_IDLE;
    end else begin
      unique case (state_q)
        ADCSEQ_IDLE: begin
          tad_q <= 4'h0;
          dly_q <= 3'h0;
          if (start & use_rc) begin
            state_q <= ADCSEQ_DELAY;
          end else if (start) begin
            state_q <= ADCSEQ_CONV;
          end
        end
        ADCSEQ_DELAY: begin
          dly_q <= dly_q + 3'h1;
          if (dly_q == 3'(`ADCSEQ_INSTR_CLKS - 1)) begin
            state_q <= ADCSEQ_CONV;
          end
        end
        ADCSEQ_CONV: begin
          if (tad_tick) begin
            tad_q <= tad_q + 4'h1;
          end
        end
      endcase
    end
  end

  // successive approximation register, MSB first
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      trial_q <= 8'h00;
      nres_q <= 4'h0;
      last_q <= 1'b0;
      hold_q <= 1'b0;
    end else if ((state_q != ADCSEQ_CONV) | sleep_abort | sw_abort |
                 finish) begin
      trial_q <= 8'h00;
      nres_q <= 4'h0;
      last_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (tad_tick && tad_q == 4'h0) begin
      trial_q <= 8'h80;
      hold_q <= 1'b1;
    end else if (last_bit) begin
      trial_q <= resolved;
      if (bit_idx != 3'h0) begin
        trial_q[bit_idx - 3'h1] <= 1'b1;
      end
      nres_q <= nres_q + 4'h1;
      last_q <= comparator_i;
    end
  end

  // unresolved low bits copy the last resolved bit
  function automatic logic [7:0] fill_partial(
    input logic [7:0] code,
    input logic [3:0] nres,
    input logic last
  );
    logic [7:0] out;
    out = code;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < 4'd8 - nres) begin
        out[i] = last;
      end
    end
    return out;
  endfunction

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      result_q <= 8'h00;
    end else if (finish) begin
      result_q <= trial_q;
    end else if (sw_abort) begin
      result_q <= fill_partial(trial_q, nres_q, last_q);
    end else if (res_wr) begin
      result_q <= hwdata_i[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // done flag, enable, wake and power down
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      flag_q <= 1'b0;
    end else if (finish) begin
      flag_q <= 1'b1;
    end else if (irq_wr & hwdata_i[`ADCSEQ_IRQ_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_en_q <= 1'b0;
    end else if (irq_wr) begin
      irq_en_q <= hwdata_i[`ADCSEQ_IRQ_EN];
    end
  end

  assign done_flag_o = flag_q;
  assign wake_o = flag_q & irq_en_q;

  // converter off in sleep (with RC clock only after a finish with irq disabled) while on bit stays set
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pd_q <= 1'b0;
    end else if (~sleep_i) begin
      pd_q <= 1'b0;
    end else if (~use_rc | sleep_pd_finish) begin
      pd_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // analog side
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      analog_o <= '0;
    end else begin
      analog_o.enable <= powered;
      analog_o.hold <= hold_q;
      analog_o.channel <= chs_q;
      analog_o.trial <= trial_q;
    end
  end

endmodule

/* File: inc/adcseq_cfg.svh */
`ifndef ADCSEQ_CFG_SVH
`define ADCSEQ_CFG_SVH

// register byte offsets
`define ADCSEQ_OFF_CTL 8'h00
`define ADCSEQ_OFF_CFG 8'h04
`define ADCSEQ_OFF_RES 8'h08
`define ADCSEQ_OFF_IRQ 8'h0C

// conversion_control fields
`define ADCSEQ_CTL_ON 0
`define ADCSEQ_CTL_GO 1
`define ADCSEQ_CTL_CHS_LO 2
`define ADCSEQ_CTL_CHS_HI 5
`define ADCSEQ_CTL_RST 8'h00

// converter_config fields
`define ADCSEQ_CFG_REF_LO 0
`define ADCSEQ_CFG_REF_HI 1
`define ADCSEQ_CFG_CS_LO 4
`define ADCSEQ_CFG_CS_HI 6
`define ADCSEQ_CFG_RST 8'h00

// flag/enable register fields
`define ADCSEQ_IRQ_FLAG 0
`define ADCSEQ_IRQ_EN 1

// timing
`define ADCSEQ_CLK_NS 100
`define ADCSEQ_RC_PERIOD_NS 1600
`define ADCSEQ_RC_DIV (`ADCSEQ_RC_PERIOD_NS / `ADCSEQ_CLK_NS)
`define ADCSEQ_INSTR_CLKS 4
`define ADCSEQ_TAD_PER_CONV 10

`endif

/* File: inc/adcseq_pkg.sv */
package adcseq_pkg;

  typedef enum logic [1:0] {
    ADCSEQ_IDLE,
    ADCSEQ_DELAY,
    ADCSEQ_CONV
  } adcseq_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } adcseq_aphase_t;

  typedef struct packed {
    logic enable;
    logic hold;
    logic [3:0] channel;
    logic [7:0] trial;
  } adcseq_ana_t;

endpackage

/* File: sim/adcseq_top_checker.sv */
`timescale 1ns/100ps
module adcseq_top_checker
  import adcseq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic special_trigger_i,
  input wire logic timer_clear_o,
  input wire logic done_flag_o,
  input wire logic wake_o,
  input wire adcseq_ana_t analog_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd;
    hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  endsequence
  sequence s_ctl_wr;
    hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == 8'h00;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_RST_CLEAR: assert property (disable iff (1'b0)
    sys_rst_i |=> !done_flag_o && !wake_o && analog_o == '0)
    else $error("reset left state set");
  AST_TRIG_CLEAR: assert property (special_trigger_i |=> timer_clear_o)
    else $error("timer clear missing");
  AST_CLEAR_CAUSE: assert property ($rose(timer_clear_o) |->
    $past(special_trigger_i)) else $error("timer clear without trigger");
  AST_WAKE_FLAG: assert property (wake_o |-> done_flag_o)
    else $error("wake without flag");
  AST_FLAG_CLEAR: assert property ($fell(done_flag_o) &&
    !$past(sys_rst_i) |-> $past(hwdata_i[0]) && $past(hsel_i && hready_i &&
    htrans_i[1] && hwrite_i && haddr_i[7:0] == 8'h0C, 2))
    else $error("flag fell without clear write");
  AST_DONE_STOP: assert property ($rose(done_flag_o) |->
    analog_o.hold ##1 !analog_o.hold) else $error("finish not at conversion");
  AST_MSB_FIRST: assert property ($rose(analog_o.hold) |->
    analog_o.trial == 8'h80) else $error("first trial not msb");
  AST_CHAN_MAP: assert property (s_ctl_wr |=> ##2
    analog_o.channel == $past(hwdata_i[5:2], 2)) else $error("channel wrong");
  AST_READ_ZERO: assert property (s_rd |=> hrdata_o[31:8] == 24'h0 &&
    ($past(haddr_i[7:0]) != 8'h00 || hrdata_o[7:6] == 2'b00))
    else $error("unimplemented bits set");
  AST_HOLD_POWER: assert property (analog_o.hold |-> analog_o.enable)
    else $error("converting while off");
endmodule
bind adcseq_top adcseq_top_checker i_adcseq_top_checker (.*);

/* File: sim/adcseq_ana_model.sv */
`timescale 1ns/100ps
module adcseq_ana_model
  import adcseq_pkg::*;
(
  input wire logic mclk_i,
  input wire adcseq_ana_t analog_i,
  input wire logic [7:0] level_i,
  output logic comparator_o
);
  logic flip_q = 1'b0;
  // unpowered or sampling: no stale compare result
  always_ff @(posedge mclk_i) begin
    flip_q <= ~flip_q;
  end
  assign comparator_o = (analog_i.enable && analog_i.hold) ?
    (level_i >= analog_i.trial) : flip_q;
endmodule

/* File: sim/adcseq_bench.sv */
`timescale 1ns/100ps
module adcseq_bench;
  import adcseq_pkg::*;
  logic mclk_i = 0, sys_rst_i = 1, hsel_i = 0, hwrite_i = 0, ie = 0;
  logic sleep_i = 0, special_trigger_i = 0, comparator_i;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o;
  logic [1:0] htrans_i = 0, ref_select_o;
  logic [7:0] level = 0;
  logic hreadyout_o, hresp_o, timer_clear_o, done_flag_o, wake_o;
  logic [2:0] cs_list [8] = '{0, 1, 2, 4, 5, 6, 3, 7};
  adcseq_ana_t analog_o;
  int failures = 0, total_checks = 0, cycles = 0;
  adcseq_top i_adcseq_top (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .sleep_i(sleep_i),
    .special_trigger_i(special_trigger_i), .comparator_i(comparator_i),
    .analog_o(analog_o), .timer_clear_o(timer_clear_o),
    .done_flag_o(done_flag_o), .wake_o(wake_o), .ref_select_o(ref_select_o));
  adcseq_ana_model i_adcseq_ana_model (.mclk_i(mclk_i), .analog_i(analog_o),
    .level_i(level), .comparator_o(comparator_i));
  initial forever #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk_i);
    hsel_i <= 1;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    hsel_i <= 0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    r = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [31:0] r;
    bus(1, a, {24'h0, d}, r);
  endtask
  task automatic rd(input logic [7:0] a, e, input string m);
    logic [31:0] r;
    bus(0, a, 32'h0, r);
    chk(r, {24'h0, e}, m);
  endtask
  function automatic int bit_conversion_period(input logic [2:0] cs);
    case (cs)
      3'b000: return 2;
      3'b001: return 8;
      3'b010: return 32;
      3'b100: return 4;
      3'b101: return 16;
      3'b110: return 64;
      default: return 16;
    endcase
  endfunction
  function automatic bit partial_ok(input logic [7:0] lv, r);
    logic [7:0] e;
    for (int k = 1; k < 8; k++) begin
      e = lv;
      for (int b = 0; b < 8 - k; b++) e[b] = lv[8-k];
      if (r === e) return 1;
    end
    return 0;
  endfunction
  task automatic convert(input logic [2:0] cs, input bit slp, trg);
    int n, t, lo;
    logic [1:0] rf;
    n = 0;
    rf = 2'($urandom);
    t = bit_conversion_period(cs);
    lo = (cs[1:0] == 2'b11) ? 4 + 9 * t : 9 * t;
    level <= $urandom;
    wr(8'h04, {1'b0, cs, 2'b00, rf});
    wr(8'h0C, {6'h0, ie, 1'b0});
    chk(ref_select_o, rf, "reference");
    wr(8'h00, 8'h01);
    if (trg) begin
      @(posedge mclk_i);
      special_trigger_i <= 1;
      @(posedge mclk_i);
      special_trigger_i <= 0;
    end else begin
      wr(8'h00, 8'h03);
    end
    sleep_i <= slp;
    while (done_flag_o !== 1'b1) begin
      @(negedge mclk_i);
      n++;
    end
    chk(n >= lo && n <= lo + t + 3, 1, "duration");
    @(negedge mclk_i);
    chk(wake_o, ie, "wake");
    chk(analog_o.enable, !slp || ie, "power");
    @(posedge mclk_i);
    sleep_i <= 0;
    rd(8'h00, 8'h01, "status");
    rd(8'h08, level, "result");
    wr(8'h0C, {6'h0, ie, 1'b1});
    rd(8'h0C, {6'h0, ie, 1'b0}, "flag");
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    void'($urandom(44849));
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 0;
    for (int a = 0; a < 5; a++) rd(8'(4 * a), 8'h00, "reset value");
    for (int c = 0; c < 16; c++) begin
      wr(8'h00, {2'b11, 4'(c), 2'b00});
      rd(8'h00, {2'b00, 4'(c), 2'b00}, "channel");
    end
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00, "unmapped");
    wr(8'h08, 8'hA5);
    rd(8'h08, 8'hA5, "result write");
    chk({hreadyout_o, hresp_o}, 2'b10, "bus response");
    $display("test registers done");
    foreach (cs_list[i]) convert(cs_list[i], 0, 0);
    convert(3'b000, 0, 1);
    convert(3'b011, 1, 0);
    ie = 1;
    convert(3'b111, 1, 0);
    ie = 0;
    wr(8'h0C, 8'h00);
    $display("test conversions done");
    level <= $urandom;
    wr(8'h04, 8'h60);
    wr(8'h00, 8'h03);
    repeat (300) @(posedge mclk_i);
    wr(8'h00, 8'h01);
    bus(0, 8'h08, 32'h0, r);
    chk(partial_ok(level, r[7:0]), 1, "partial");
    wr(8'h00, 8'h03);
    repeat (100) @(posedge mclk_i);
    sleep_i <= 1;
    repeat (900) @(posedge mclk_i);
    chk(done_flag_o, 0, "sleep abort");
    chk(analog_o.enable, 0, "sleep off");
    bus(0, 8'h00, 32'h0, r);
    chk(r[0], 1, "on kept");
    sleep_i <= 0;
    $display("test aborts done");
    wr(8'h00, 8'h03);
    repeat (50) @(posedge mclk_i);
    sys_rst_i <= 1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 0;
    rd(8'h00, 8'h00, "reset ctl");
    rd(8'h04, 8'h00, "reset cfg");
    chk(analog_o, 0, "reset analog");
    $display("test reset done");
    end_of_test;
  end
endmodule
